// ---- verilog/ifc_map.vh ----
// Constants for the instruction fetch cache controller
`ifndef IFC_MAP_VH
`define IFC_MAP_VH
`define IFC_CLK_PERIOD_NS 8
`define IFC_LINE_BYTES 32
`define IFC_LINE_WORDS 8
`define IFC_SETS 16
`define IFC_IDX_LO 5
`define IFC_IDX_HI 8
`define IFC_TAG_LO 9
`define IFC_TAG_W 23
`define IFC_PAGE_LO 10
`define IFC_PAGE_LINE_LAST 5'h1f
`define IFC_RESET_PAGE 22'h3fffff
`define IFC_BW_32 2'h0
`define IFC_BW_64 2'h1
`define IFC_BW_128 2'h2
`define IFC_ISS_DEPTH 2'h2
`endif

// ---- verilog/ifc_line_ram.v ----
// Line data array of the fetch cache, one 256-bit line per set, registered read
`timescale 1ns/1ps
module ifc_line_ram (
	input wire clock,
	input wire clk_en,
	input wire wr_en,
	input wire [3:0] wr_idx,
	input wire [255:0] wr_data,
	input wire rd_en,
	input wire [3:0] rd_idx,
	output reg [255:0] rd_data
);
	reg [255:0] mem [0:15];
	always @(posedge clock)
	begin
		if (clk_en)
		begin
			if (wr_en)
				mem[wr_idx] <= wr_data;
			if (rd_en)
				rd_data <= mem[rd_idx];
		end
	end
endmodule

// ---- verilog/ifc_pair_buf.v ----
// Two-entry buffer between the controller and the instruction unit
`timescale 1ns/1ps
module ifc_pair_buf (
	input wire clock,
	input wire rst,
	input wire clk_en,
	input wire in_valid,
	output reg in_ready,
	input wire [64:0] in_data,
	output reg out_valid,
	input wire out_ready,
	output reg [64:0] out_data
);
	reg [64:0] spare_r;
	reg [1:0] cnt_r;
	wire push;
	wire pop;
	reg [1:0] cnt_nxt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @*
	begin
		cnt_nxt = cnt_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'h1;
	end
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= 2'h0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
			out_data <= 65'h0;
			spare_r <= 65'h0;
		end
		else if (clk_en)
		begin
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != 2'h2);
			out_valid <= (cnt_nxt != 2'h0);
			// Head register feeds the port, spare holds the second word
			if (pop)
				out_data <= (cnt_r == 2'h2) ? spare_r : in_data;
			else if (push && cnt_r == 2'h0)
				out_data <= in_data;
			if (push && ((cnt_r == 2'h1 && !pop) || cnt_r == 2'h2))
				spare_r <= in_data;
		end
	end
endmodule

// ---- verilog/ifc_fetch_ctl.v ----
// Instruction fetch cache controller: lookup, line fill, bus read port
//
// What this block does
// - Hit returns the addressed instruction pair, one pair every two cycles.
// - Reads over a 128-bit bus port, also 32-bit and 64-bit buses.
// - Works at core-to-bus clock ratios n:1, n:2, n:3.
// - Optionally fetches up to three extra lines after a miss.
// - Executes touch, single-line invalidate and flash invalidate.
// - Searches array by virtual address while translation runs in the same cycle.
// - On a miss requests the whole 32-byte line by real address.
// - Requests the full line even for caching-inhibited pages.
// - Request carries exact instruction address so target word comes first.
// - Arriving data goes to fill buffer and can be forwarded early.
// - Complete cacheable line in fill buffer is written to the array.
// - Inhibited line never enters array; stays buffered until the first data beat of the next line read.
// - Errored fill is not written to array but may still forward.
// - Pairs from an errored line carry a machine check flag.
// - Issued line read completes and is written even after branching away.
// - New requests are looked up at once while a fill continues.
// - New miss cancels a previous request not yet issued.
// - New miss is presented immediately behind an issued read.
// - An issued bus request is never aborted except by reset.
// - Reset marks the reset page inhibited and flash-invalidates the cache.
// - Lines are allocated only from pages with inhibit cleared, except that a touch checks op_ci only, not the reset page.
// - Two-bit field selects 0 to 3 extra lines, cacheable and absent only.
// - Extra lines never cross the aligned 1KB page of the missed line.
`timescale 1ns/1ps
`include "ifc_map.vh"
module ifc_fetch_ctl (
	input wire clock,
	input wire rst,
	input wire clk_en,
	input wire fetch_req,
	input wire [31:0] fetch_va,
	input wire [31:0] fetch_ra,
	input wire fetch_ci,
	output reg fetch_ready,
	output wire pair_valid,
	output wire [63:0] pair_data,
	output wire pair_mchk,
	input wire pair_ready,
	input wire op_touch,
	input wire op_inval,
	input wire op_flash,
	input wire [31:0] op_va,
	input wire [31:0] op_ra,
	input wire op_ci,
	input wire [1:0] speculative_line_count,
	input wire boot_ci_release,
	input wire bus_clk,
	input wire [1:0] bus_width,
	output reg bus_req,
	output reg [31:0] bus_addr,
	input wire bus_ack,
	input wire bus_dvalid,
	input wire bus_last,
	input wire bus_err,
	input wire [127:0] bus_data
);
	localparam ST_IDLE = 3'h1;
	localparam ST_LOOK = 3'h2;
	localparam ST_WAIT = 3'h4;

	function [255:0] put_words;
		input [255:0] cur;
		input [127:0] d;
		input [2:0] ptr;
		input [1:0] bw;
		integer i;
		reg [2:0] w;
		begin
			put_words = cur;
			for (i = 0; i < 4; i = i + 1)
			begin
				w = ptr + i[2:0];
				if (i < (1 << bw))
					put_words[w*32 +: 32] = d[i*32 +: 32];
			end
		end
	endfunction

	function [7:0] word_mask;
		input [2:0] ptr;
		input [1:0] bw;
		integer i;
		reg [2:0] w;
		begin
			word_mask = 8'h00;
			for (i = 0; i < 4; i = i + 1)
			begin
				w = ptr + i[2:0];
				if (i < (1 << bw))
					word_mask[w] = 1'b1;
			end
		end
	endfunction

	// Synchronisers for the bus side; the link clock is sampled, not used as a clock
	reg lclk_s1, lclk_s2, lclk_s3;
	reg ack_s1, ack_s2, dv_s1, dv_s2, last_s1, last_s2, err_s1, err_s2;
	reg [1:0] bw_s1, bw_s2;
	reg [127:0] dat_s1, dat_s2;
	wire bedge = lclk_s2 && !lclk_s3;
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			{lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
			{ack_s1, ack_s2, dv_s1, dv_s2} <= 4'h0;
			{last_s1, last_s2, err_s1, err_s2} <= 4'h0;
			bw_s1 <= 2'h0;
			bw_s2 <= 2'h0;
			dat_s1 <= 128'h0;
			dat_s2 <= 128'h0;
		end
		else if (clk_en)
		begin
			lclk_s1 <= bus_clk;
			lclk_s2 <= lclk_s1;
			lclk_s3 <= lclk_s2;
			ack_s1 <= bus_ack;
			ack_s2 <= ack_s1;
			dv_s1 <= bus_dvalid;
			dv_s2 <= dv_s1;
			last_s1 <= bus_last;
			last_s2 <= last_s1;
			err_s1 <= bus_err;
			err_s2 <= err_s1;
			bw_s1 <= bus_width;
			bw_s2 <= bw_s1;
			dat_s1 <= bus_data;
			dat_s2 <= dat_s1;
		end
	end

	reg [2:0] st_r, st_nxt;
	reg [31:0] lk_va_r, lk_ra_r;
	reg lk_ci_r;
	reg [`IFC_TAG_W-1:0] tag_r [0:`IFC_SETS-1];
	reg [`IFC_SETS-1:0] valid_r;
	reg boot_ci_r;
	wire [255:0] rd_data;
	// Fill buffer and issued-read queue
	reg [255:0] fb_data_r;
	reg [7:0] fb_have_r;
	reg [26:0] fb_line_r;
	reg [2:0] fb_ptr_r;
	reg fb_busy_r, fb_err_r, fb_live_r;
	reg [31:0] iss0_ra_r, iss0_va_r, iss1_ra_r, iss1_va_r;
	reg iss0_ci_r, iss1_ci_r;
	reg [1:0] iss_cnt_r;
	reg [31:0] pend_ra_r, pend_va_r;
	reg pend_v_r, pend_ci_r, pend_prim_r;
	reg [1:0] spec_left_r;
	reg [31:0] spec_ra_r, spec_va_r;

	wire take = fetch_req && fetch_ready;
	wire op_take = fetch_ready && !fetch_req;
	wire [3:0] lk_idx = lk_va_r[`IFC_IDX_HI:`IFC_IDX_LO];
	wire arr_hit = valid_r[lk_idx] && tag_r[lk_idx] == lk_va_r[31:`IFC_TAG_LO] && !lk_ci_r;
	wire [2:0] pw = {lk_va_r[4:3], 1'b0};
	wire fb_pair = fb_live_r && fb_line_r == lk_ra_r[31:5] && fb_have_r[pw] && fb_have_r[pw+3'h1];
	wire [63:0] arr_pair = rd_data[lk_va_r[4:3]*64 +: 64];
	wire [63:0] fb_pair_d = fb_data_r[lk_va_r[4:3]*64 +: 64];
	wire buf_in_ready;
	reg buf_push;
	reg [64:0] buf_in;

	// Reset page is inhibited until software releases it
	wire ci_eff = fetch_ci || (boot_ci_r && fetch_ra[31:`IFC_PAGE_LO] == `IFC_RESET_PAGE);

	function in_flight;
		input [26:0] line;
		begin
			in_flight = (pend_v_r && pend_ra_r[31:5] == line)
				|| (iss_cnt_r != 2'h0 && iss0_ra_r[31:5] == line)
				|| (iss_cnt_r == 2'h2 && iss1_ra_r[31:5] == line);
		end
	endfunction

	function present;
		input [31:0] va;
		begin
			present = valid_r[va[`IFC_IDX_HI:`IFC_IDX_LO]]
				&& tag_r[va[`IFC_IDX_HI:`IFC_IDX_LO]] == va[31:`IFC_TAG_LO];
		end
	endfunction

	// Lookup sequence; a new fetch abandons a wait without touching the fill
	reg nr_v, nr_ci;
	reg [31:0] nr_ra, nr_va;
	always @*
	begin
		st_nxt = st_r;
		buf_push = 1'b0;
		buf_in = 65'h0;
		nr_v = 1'b0;
		nr_ci = 1'b0;
		nr_ra = lk_ra_r;
		nr_va = lk_va_r;
		case (st_r)
			ST_IDLE:
			begin
				if (take)
					st_nxt = ST_LOOK;
				else if (op_take && op_touch && !op_ci && !present(op_va)
					&& !in_flight(op_ra[31:5]))
				begin
					nr_v = 1'b1;
					nr_ra = op_ra;
					nr_va = op_va;
				end
			end
			ST_LOOK:
			begin
				if (arr_hit)
				begin
					buf_push = 1'b1;
					buf_in = {1'b0, arr_pair};
				end
				else if (fb_pair)
				begin
					buf_push = 1'b1;
					buf_in = {fb_err_r, fb_pair_d};
				end
				else
				begin
					st_nxt = ST_WAIT;
					nr_v = !in_flight(lk_ra_r[31:5]);
					nr_ci = lk_ci_r;
				end
				if (buf_push)
					st_nxt = buf_in_ready ? ST_IDLE : ST_LOOK;
			end
			ST_WAIT:
			begin
				if (take)
					st_nxt = ST_LOOK;
				else if (fb_pair && buf_in_ready)
				begin
					buf_push = 1'b1;
					buf_in = {fb_err_r, fb_pair_d};
					st_nxt = ST_IDLE;
				end
			end
			default:
				st_nxt = ST_IDLE;
		endcase
	end

	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			fetch_ready <= 1'b0;
			lk_va_r <= 32'h0;
			lk_ra_r <= 32'h0;
			lk_ci_r <= 1'b0;
			boot_ci_r <= 1'b1;
		end
		else if (clk_en)
		begin
			st_r <= st_nxt;
			fetch_ready <= (st_nxt == ST_IDLE) || (st_nxt == ST_WAIT);
			if (boot_ci_release)
				boot_ci_r <= 1'b0;
			if (take)
			begin
				lk_va_r <= fetch_va;
				lk_ra_r <= fetch_ra;
				lk_ci_r <= ci_eff;
			end
		end
	end

	// Request presentation: one pending request, at most two issued reads
	wire ack_ev = bedge && ack_s2 && bus_req;
	wire fill_beat = bedge && dv_s2 && iss_cnt_r != 2'h0;
	wire line_done = fill_beat && last_s2;
	wire [4:0] room = `IFC_PAGE_LINE_LAST - pend_ra_r[9:5];
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pend_v_r <= 1'b0;
			pend_ci_r <= 1'b0;
			pend_prim_r <= 1'b0;
			pend_ra_r <= 32'h0;
			pend_va_r <= 32'h0;
			spec_left_r <= 2'h0;
			spec_ra_r <= 32'h0;
			spec_va_r <= 32'h0;
			bus_req <= 1'b0;
			bus_addr <= 32'h0;
		end
		else if (clk_en)
		begin
			if (nr_v && !ack_ev)
			begin
				// Unacknowledged request is simply replaced
				pend_v_r <= 1'b1;
				pend_ra_r <= nr_ra;
				pend_va_r <= nr_va;
				pend_ci_r <= nr_ci;
				pend_prim_r <= 1'b1;
				spec_left_r <= 2'h0;
			end
			else if (ack_ev)
			begin
				pend_v_r <= nr_v;
				pend_ra_r <= nr_ra;
				pend_va_r <= nr_va;
				pend_ci_r <= nr_ci;
				pend_prim_r <= 1'b1;
				if (nr_v || !pend_prim_r || pend_ci_r)
					spec_left_r <= nr_v ? 2'h0 : spec_left_r;
				else
					spec_left_r <= (room < {3'h0, speculative_line_count}) ? room[1:0]
						: speculative_line_count;
				spec_ra_r <= {pend_ra_r[31:5] + 27'h1, 5'h0};
				spec_va_r <= {pend_va_r[31:5] + 27'h1, 5'h0};
			end
			else if (!pend_v_r && spec_left_r != 2'h0)
			begin
				if (!present(spec_va_r) && !in_flight(spec_ra_r[31:5]))
				begin
					pend_v_r <= 1'b1;
					pend_ra_r <= spec_ra_r;
					pend_va_r <= spec_va_r;
					pend_ci_r <= 1'b0;
					pend_prim_r <= 1'b0;
					// Remaining extra lines follow once this one is acked
					spec_left_r <= spec_left_r - 2'h1;
				end
				else
				begin
					spec_left_r <= spec_left_r - 2'h1;
					spec_ra_r <= {spec_ra_r[31:5] + 27'h1, 5'h0};
					spec_va_r <= {spec_va_r[31:5] + 27'h1, 5'h0};
				end
			end
			// Held until taken; cancel only swaps an unacknowledged address
			bus_req <= (bus_req && !ack_ev)
				|| (pend_v_r && !ack_ev && (iss_cnt_r != `IFC_ISS_DEPTH || line_done));
			bus_addr <= pend_ra_r;
		end
	end

	// Fill buffer, issued queue and array update
	wire [1:0] bw = (bw_s2 > `IFC_BW_128) ? `IFC_BW_128 : bw_s2;
	wire [2:0] start_ptr = iss0_ra_r[4:2] & ~((3'h1 << bw) - 3'h1);
	wire [2:0] cur_ptr = fb_busy_r ? fb_ptr_r : start_ptr;
	wire [255:0] fb_merge = put_words(fb_data_r, dat_s2, cur_ptr, bw);
	wire [7:0] have_merge = (fb_busy_r ? fb_have_r : 8'h00) | word_mask(cur_ptr, bw);
	wire err_merge = (fb_busy_r && fb_err_r) || err_s2;
	wire wr_line = line_done && !err_merge && !iss0_ci_r && have_merge == 8'hff;
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			fb_data_r <= 256'h0;
			fb_have_r <= 8'h00;
			fb_line_r <= 27'h0;
			fb_ptr_r <= 3'h0;
			{fb_busy_r, fb_err_r, fb_live_r} <= 3'h0;
			iss_cnt_r <= 2'h0;
			{iss0_ra_r, iss0_va_r, iss1_ra_r, iss1_va_r} <= 128'h0;
			{iss0_ci_r, iss1_ci_r} <= 2'h0;
			valid_r <= {`IFC_SETS{1'b0}};
		end
		else if (clk_en)
		begin
			if (fill_beat)
			begin
				// First beat of a line displaces the buffered line
				fb_data_r <= fb_merge;
				fb_have_r <= have_merge;
				fb_err_r <= err_merge;
				fb_line_r <= iss0_ra_r[31:5];
				fb_ptr_r <= cur_ptr + (3'h1 << bw);
				fb_busy_r <= !last_s2;
				fb_live_r <= 1'b1;
			end
			if (ack_ev && !line_done)
				iss_cnt_r <= iss_cnt_r + 2'h1;
			else if (line_done && !ack_ev)
				iss_cnt_r <= iss_cnt_r - 2'h1;
			if (line_done)
			begin
				iss0_ra_r <= iss1_ra_r;
				iss0_va_r <= iss1_va_r;
				iss0_ci_r <= iss1_ci_r;
			end
			if (ack_ev)
			begin
				if (iss_cnt_r == 2'h0 || (iss_cnt_r == 2'h1 && line_done))
				begin
					iss0_ra_r <= pend_ra_r;
					iss0_va_r <= pend_va_r;
					iss0_ci_r <= pend_ci_r;
				end
				else
				begin
					iss1_ra_r <= pend_ra_r;
					iss1_va_r <= pend_va_r;
					iss1_ci_r <= pend_ci_r;
				end
			end
			if (wr_line)
				valid_r[iss0_va_r[`IFC_IDX_HI:`IFC_IDX_LO]] <= 1'b1;
			// Management clears act after the fill; a flash always wins, an invalidate only if its line was already present
			if (op_take && op_inval && present(op_va))
				valid_r[op_va[`IFC_IDX_HI:`IFC_IDX_LO]] <= 1'b0;
			if (op_take && op_flash)
				valid_r <= {`IFC_SETS{1'b0}};
		end
	end

	always @(posedge clock)
	begin
		if (clk_en && wr_line)
			tag_r[iss0_va_r[`IFC_IDX_HI:`IFC_IDX_LO]] <= iss0_va_r[31:`IFC_TAG_LO];
	end

	ifc_line_ram u_ram (
		.clock(clock),
		.clk_en(clk_en),
		.wr_en(wr_line),
		.wr_idx(iss0_va_r[`IFC_IDX_HI:`IFC_IDX_LO]),
		.wr_data(fb_merge),
		.rd_en(take),
		.rd_idx(fetch_va[`IFC_IDX_HI:`IFC_IDX_LO]),
		.rd_data(rd_data)
	);

	ifc_pair_buf u_buf (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.in_valid(buf_push),
		.in_ready(buf_in_ready),
		.in_data(buf_in),
		.out_valid(pair_valid),
		.out_ready(pair_ready),
		.out_data({pair_mchk, pair_data})
	);
endmodule

// ---- verification/ifc_fetch_ctl_sva.sv ----
// Port assertions for the instruction fetch cache controller
`timescale 1ns/1ps
module ifc_fetch_ctl_sva (
	input wire clock,
	input wire rst,
	input wire fetch_req,
	input wire fetch_ready,
	input wire pair_valid,
	input wire [63:0] pair_data,
	input wire pair_mchk,
	input wire pair_ready,
	input wire bus_req,
	input wire bus_ack
);
	reg ack_d_r;
	reg [3:0] ack_age_r;
	always @(posedge clock or posedge rst)
		if (rst)
			ack_d_r <= 1'b0;
		else
			ack_d_r <= bus_ack;
	// Saturates so a quiet bus never wraps back into the drop window
	always @(posedge clock or posedge rst)
		if (rst)
			ack_age_r <= 4'hf;
		else if (bus_ack && !ack_d_r)
			ack_age_r <= 4'h0;
		else if (ack_age_r != 4'hf)
			ack_age_r <= ack_age_r + 4'h1;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_take;
		fetch_req && fetch_ready && !pair_valid;
	endsequence
	// Every take spends one cycle in lookup, hit or miss alike
	sequence s_look;
		s_take ##1 !fetch_ready;
	endsequence
	// A hit has its pair out when ready returns and still a cycle later; a miss has not
	sequence s_miss;
		s_look ##1 fetch_ready ##1 !pair_valid;
	endsequence
	a_hit_pair: assert property ($rose(pair_valid) |-> fetch_ready)
		else $error("pair delivered while lookup busy");
	a_look_short: assert property (s_look |=> fetch_ready)
		else $error("lookup blocked next fetch");
	a_miss_request: assert property (s_miss |-> ##[0:6] bus_req)
		else $error("miss raised no line request");
	a_pair_holds: assert property (pair_valid && !pair_ready |=>
		pair_valid && $stable(pair_data) && $stable(pair_mchk))
		else $error("pair changed while stalled");
	a_mchk_qual: assert property (pair_mchk |-> pair_valid)
		else $error("machine check without pair");
	a_reset_quiet: assert property ($past(rst) |-> !bus_req && !pair_valid)
		else $error("activity right after reset");
	a_req_hold: assert property ($rose(bus_req) |=> bus_req [*2])
		else $error("line request withdrawn early");
	a_req_drop: assert property ($fell(bus_req) |-> ack_age_r <= 4'h9)
		else $error("line request dropped without ack");
endmodule
bind ifc_fetch_ctl ifc_fetch_ctl_sva chk_i (.clock(clock), .rst(rst), .fetch_req(fetch_req),
	.fetch_ready(fetch_ready), .pair_valid(pair_valid), .pair_data(pair_data),
	.pair_mchk(pair_mchk), .pair_ready(pair_ready), .bus_req(bus_req), .bus_ack(bus_ack));

// ---- verification/ifc_bus_model.sv ----
// Read bus slave model: acks one line at a time, returns it in two 128-bit beats
`timescale 1ns/1ps
module ifc_bus_model (
	input wire bus_clk,
	input wire rst,
	input wire bus_req,
	input wire [31:0] bus_addr,
	input wire err_mode,
	output reg bus_ack,
	output reg bus_dvalid,
	output reg bus_last,
	output reg bus_err,
	output reg [127:0] bus_data,
	output reg [31:0] taken_addr_r,
	output reg [7:0] ack_cnt_r
);
	reg [1:0] beat_r;
	reg [127:0] dat;
	integer i;
	// Each word carries its own byte address, so misplaced words show up
	always @(posedge bus_clk or posedge rst)
	begin
		if (rst)
		begin
			{bus_ack, bus_dvalid, bus_last, bus_err} <= 4'h0;
			bus_data <= 128'h0;
			taken_addr_r <= 32'h0;
			ack_cnt_r <= 8'h0;
			beat_r <= 2'h0;
		end
		else
		begin
			{bus_ack, bus_dvalid, bus_last, bus_err} <= 4'h0;
			// Released data lines toggle so stale data is never mistaken for a beat
			bus_data <= ~bus_data;
			if (beat_r != 2'h0)
			begin
				for (i = 0; i < 4; i = i + 1)
					dat[32*i +: 32] = {taken_addr_r[31:5], taken_addr_r[4] ^ beat_r[1], i[1:0], 2'h0};
				bus_data <= dat;
				bus_dvalid <= 1'b1;
				bus_last <= beat_r[1];
				bus_err <= err_mode & beat_r[0];
				beat_r <= beat_r[1] ? 2'h0 : 2'h2;
			end
			else if (bus_req && !bus_ack)
			begin
				bus_ack <= 1'b1;
				taken_addr_r <= bus_addr;
				ack_cnt_r <= ack_cnt_r + 8'h1;
				beat_r <= 2'h1;
			end
		end
	end
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the instruction fetch cache controller
`timescale 1ns/1ps
`include "ifc_map.vh"
module tb;
	reg clock = 1'b0, bus_clk = 1'b0, rst = 1'b1;
	reg freq = 1'b0, fci = 1'b0, pr = 1'b0, err_mode = 1'b0;
	reg [31:0] fa = 32'h0, op_a = 32'h0;
	reg [2:0] op_k = 3'h0;
	reg [1:0] spec = 2'h0;
	integer error_cnt = 0, n_checks = 0, cyc = 0;
	wire fetch_ready, pair_valid, pair_mchk, bus_req, bus_ack, bus_dvalid, bus_last, bus_err;
	wire [63:0] pair_data;
	wire [31:0] bus_addr, m_addr;
	wire [127:0] bus_data;
	wire [7:0] m_acks;
	always #4 clock = ~clock;
	always #62.5 bus_clk = ~bus_clk;
	ifc_fetch_ctl ifc_fetch_ctl_i (.clock(clock), .rst(rst), .clk_en(1'b1), .fetch_req(freq),
		.fetch_va(fa), .fetch_ra(fa), .fetch_ci(fci), .fetch_ready(fetch_ready),
		.pair_valid(pair_valid), .pair_data(pair_data), .pair_mchk(pair_mchk), .pair_ready(pr),
		.op_touch(op_k[2]), .op_inval(op_k[1]), .op_flash(op_k[0]), .op_va(op_a), .op_ra(op_a),
		.op_ci(fci), .speculative_line_count(spec), .boot_ci_release(1'b0), .bus_clk(bus_clk),
		.bus_width(`IFC_BW_128), .bus_req(bus_req), .bus_addr(bus_addr), .bus_ack(bus_ack),
		.bus_dvalid(bus_dvalid), .bus_last(bus_last), .bus_err(bus_err), .bus_data(bus_data));
	ifc_bus_model ifc_bus_model_i (.bus_clk(bus_clk), .rst(rst), .bus_req(bus_req),
		.bus_addr(bus_addr), .err_mode(err_mode), .bus_ack(bus_ack), .bus_dvalid(bus_dvalid),
		.bus_last(bus_last), .bus_err(bus_err), .bus_data(bus_data), .taken_addr_r(m_addr),
		.ack_cnt_r(m_acks));
	task close_out;
	begin
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	task check(input [63:0] got, input [63:0] exp);
	begin
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// One fetch: the pair, its check flag and the number of new line reads
	task fx(input [31:0] a, input ci, input e_m, input [7:0] e_n);
		reg [7:0] c0;
	begin
		c0 = m_acks;
		@(posedge clock);
		fa <= a;
		fci <= ci;
		freq <= 1'b1;
		@(posedge clock);
		while (fetch_ready !== 1'b1)
			@(posedge clock);
		freq <= 1'b0;
		@(posedge clock);
		while (pair_valid !== 1'b1)
			@(posedge clock);
		pr <= 1'b1;
		check(pair_data, {a[31:3], 3'h4, a[31:3], 3'h0});
		check({63'h0, pair_mchk}, {63'h0, e_m});
		check({56'h0, m_acks - c0}, {56'h0, e_n});
		@(posedge clock);
		pr <= 1'b0;
	end
	endtask
	task op(input [2:0] k, input [31:0] a);
	begin
		@(posedge clock);
		op_a <= a;
		op_k <= k;
		@(posedge clock);
		while (fetch_ready !== 1'b1)
			@(posedge clock);
		op_k <= 3'h0;
	end
	endtask
	task t_miss_hit;
	begin
		fx(32'h1048, 1'b0, 1'b0, 8'h1);
		check({32'h0, m_addr}, 64'h1048);
		fx(32'h2000, 1'b0, 1'b0, 8'h1);
		fx(32'h1048, 1'b0, 1'b0, 8'h0);
	end
	endtask
	task t_inhibit;
	begin
		fx(32'h3010, 1'b1, 1'b0, 8'h1);
		fx(32'h3010, 1'b1, 1'b0, 8'h0);
		fx(32'h4000, 1'b0, 1'b0, 8'h1);
		fx(32'h3010, 1'b1, 1'b0, 8'h1);
	end
	endtask
	task t_error;
	begin
		err_mode <= 1'b1;
		fx(32'h5020, 1'b0, 1'b1, 8'h1);
		err_mode <= 1'b0;
		fx(32'h6000, 1'b0, 1'b0, 8'h1);
		fx(32'h5020, 1'b0, 1'b0, 8'h1);
	end
	endtask
	task t_ops;
		reg [7:0] c0;
	begin
		op(3'h2, 32'h1048);
		fx(32'h1048, 1'b0, 1'b0, 8'h1);
		c0 = m_acks;
		op(3'h4, 32'h7000);
		while (m_acks == c0)
			@(posedge clock);
		// Let the touched line finish so the fetch is a plain array hit
		repeat (60) @(posedge clock);
		fx(32'h7000, 1'b0, 1'b0, 8'h0);
		op(3'h1, 32'h0);
		fx(32'h2000, 1'b0, 1'b0, 8'h1);
	end
	endtask
	task t_reset_page;
	begin
		fx(32'hfffffc08, 1'b0, 1'b0, 8'h1);
		fx(32'h8000, 1'b0, 1'b0, 8'h1);
		fx(32'hfffffc08, 1'b0, 1'b0, 8'h1);
	end
	endtask
	task t_spec;
		reg [7:0] c0;
	begin
		spec <= 2'h2;
		c0 = m_acks;
		fx(32'h93c0, 1'b0, 1'b0, 8'h1);
		// Long enough for a queued extra line to be acked and drained
		repeat (600) @(posedge clock);
		check({56'h0, m_acks - c0}, 64'h2);
		spec <= 2'h3;
		c0 = m_acks;
		fx(32'h9400, 1'b0, 1'b0, 8'h1);
		repeat (600) @(posedge clock);
		check({56'h0, m_acks - c0}, 64'h4);
		spec <= 2'h0;
	end
	endtask
	always @(posedge clock)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt = error_cnt + 1;
			close_out;
		end
	end
	initial
	begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_miss_hit;
		t_inhibit;
		t_error;
		t_ops;
		t_reset_page;
		t_spec;
		close_out;
	end
endmodule
